// ===== rtl/card_regs_pkg.sv
/*
  Constants, field positions and types for the card register set.
  Assumes one clock domain; every user includes nothing and writes
  card_regs_pkg::name.
*/
package card_regs_pkg;

  // ----------------------------------------------------------------
  // Register selects for a response
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_OPCOND = 3'h0,
    SEL_IDENT  = 3'h1,
    SEL_SPEC   = 3'h2,
    SEL_ADDR   = 3'h3,
    SEL_CONFIG = 3'h4,
    SEL_STATUS = 3'h5,
    SEL_EXT    = 3'h6,
    SEL_DRIVER = 3'h7
  } reg_sel_t;

  // ----------------------------------------------------------------
  // Current-state codes of the status word
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_READY = 4'h1,
    ST_IDENT = 4'h2,
    ST_STBY  = 4'h3,
    ST_TRAN  = 4'h4,
    ST_DATA  = 4'h5,
    ST_RCV   = 4'h6,
    ST_PRG   = 4'h7,
    ST_DIS   = 4'h8,
    ST_IO    = 4'hf
  } card_state_t;

  // ----------------------------------------------------------------
  // Operating-conditions word
  // ----------------------------------------------------------------
  localparam int OPC_BUSY_BIT = 31;
  localparam int OPC_CAP_BIT = 30;
  localparam int OPC_LV_BIT = 24;
  localparam logic [8:0] OPC_VDD_WINDOW = 9'h1ff;
  localparam int OPC_VDD_LSB = 15;

  // ----------------------------------------------------------------
  // Fixed field values of the card-specific data
  // ----------------------------------------------------------------
  localparam logic [1:0] SPEC_STRUCT = 2'h1;
  localparam logic [7:0] READ_ACCESS_TIME = 8'h0e;
  localparam logic [7:0] CLOCK_ACCESS_CYCLES = 8'h00;
  localparam logic [7:0] TRAN_SPEED_DS = 8'h32;
  localparam logic [11:0] COMMAND_CLASSES = 12'h5b5;
  localparam logic [3:0] BLOCK_LENGTH_CODE = 4'h9;
  localparam logic [6:0] ERASE_SECTOR_SIZE = 7'h7f;
  localparam logic [6:0] GROUP_SIZE = 7'h00;
  localparam logic [2:0] WRITE_SPEED_FACTOR = 3'h2;
  localparam int SPEC_COPY_BIT = 14;
  localparam int SPEC_PERM_BIT = 13;
  localparam int SPEC_TMP_BIT = 12;
  localparam int SPEC_SIZE_LSB = 48;
  localparam logic [31:0] WHOLE_BLOCK_BYTES = 32'h0000_0200;

  // ----------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------
  localparam logic [3:0] CFG_STRUCT = 4'h0;
  localparam logic [3:0] CFG_SPEC = 4'h2;
  localparam logic [3:0] SUPPORTED_BUS_WIDTHS = 4'h5;
  localparam logic [3:0] CFG_CMD_SUPPORT = 4'h3;
  localparam int CFG_WIDTHS_LSB = 48;
  localparam int CFG_CMD_LSB = 32;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam logic [31:0] STATUS_ERR_MASK = 32'hfff9_8008;
  localparam int STAT_BLKLEN_BIT = 29;
  localparam int STAT_OVERWRITE_BIT = 16;
  localparam int STAT_LOCK_BIT = 25;
  localparam int STAT_ECC_DIS_BIT = 14;
  localparam int STAT_ERASE_BIT = 13;
  localparam int STAT_STATE_LSB = 9;
  localparam int STAT_RDY_BIT = 8;
  localparam int STAT_APP_BIT = 5;

  // ----------------------------------------------------------------
  // Extended status block fields
  // ----------------------------------------------------------------
  localparam logic [1:0] ACTIVE_BUS_WIDTH_1 = 2'b00;
  localparam logic [1:0] ACTIVE_BUS_WIDTH_4 = 2'b10;
  localparam logic [7:0] EXT_SPEED_CLASS = 8'h04;
  localparam logic [3:0] EXT_AU_SIZE = 4'h9;
  localparam logic [15:0] EXT_ERASE_SIZE = 16'h0020;
  localparam logic [5:0] EXT_ERASE_TIMEOUT = 6'h01;
  localparam logic [1:0] EXT_ERASE_OFFSET = 2'b11;
  localparam logic [3:0] EXT_UHS_GRADE = 4'h3;
  localparam logic [3:0] EXT_UHS_AU = 4'hc;

  // ----------------------------------------------------------------
  // Checksum
  // ----------------------------------------------------------------
  localparam logic [6:0] CRC7_POLY = 7'h09;

endpackage

// ===== rtl/crc_if.sv
/*
  Carrier between a register image and its checksum generator.
  Assumes the generator is purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface crc_if;
  logic [119:0] data;
  logic [6:0] crc;
  modport calc (input data, output crc);
  modport user (output data, input crc);
endinterface
`default_nettype wire

// ===== rtl/crc7_gen.sv
/*
  Seven-bit checksum over a 120-bit register image, MSB first.
  Assumes the image is stable within the cycle; no state inside.
*/
`timescale 1ns/1ps
`default_nettype none
module crc7_gen (
  crc_if.calc port
);

  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    fb = 1'b0;
    for (int i = 119; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ card_regs_pkg::CRC7_POLY;
      end
    end
    return c;
  endfunction

  assign port.crc = crc7(port.data);

endmodule
`default_nettype wire

// ===== rtl/card_register_set.sv
/*
  Card-side register set: operating conditions, identity, card-specific
  data, relative address, configuration, status word, extended status.
  Assumes request and event inputs come from card logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module card_register_set #(
  parameter logic UHS_CAPABLE = 1'b1,
  parameter logic HIGH_CAPACITY = 1'b1,
  parameter logic [21:0] SIZE_FIELD = 22'h00_ee87,
  parameter logic [7:0] MAKER_CODE = 8'h5a,          // Arbitrary value
  parameter logic [15:0] APPLICATION_CODE = 16'h4142, // Arbitrary value
  parameter logic [39:0] PRODUCT_NAME = 40'h4e_4f_4e_41_4d, // Arbitrary
  parameter logic [7:0] PRODUCT_REVISION = 8'h10,    // Arbitrary value
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,
  parameter logic [7:0] MFG_YEAR = 8'h00,
  parameter logic [3:0] MFG_MONTH = 4'h1,
  parameter logic [2:0] SECURITY_VERSION = 3'h3,
  parameter logic [31:0] MAKER_RESERVED = 32'h0000_0000, // Arbitrary
  parameter logic [31:0] PROTECTED_AREA = 32'h0500_0000,
  parameter logic [7:0] PERFORMANCE_MOVE = 8'h02
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic init_done,
  input wire logic req_valid,
  input wire logic [2:0] req_sel,
  input wire logic prog_valid,
  input wire logic [127:0] prog_data,
  input wire logic addr_wr,
  input wire logic [15:0] addr_data,
  input wire logic blklen_valid,
  input wire logic [31:0] blklen,
  input wire logic [31:0] status_evt,
  input wire logic [3:0] current_state,
  input wire logic lock_flag,
  input wire logic data_ready,
  input wire logic app_command_flag,
  input wire logic ecc_disabled,
  input wire logic erase_state,
  input wire logic bus4_mode,
  output logic card_ready,
  output logic resp_valid,
  output logic [511:0] resp_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ready;
    logic [31:0] err;
    logic copy;
    logic perm;
    logic tmp;
    logic crc_prog;
    logic [6:0] spec_crc;
    logic [15:0] addr;
    logic resp_valid;
    logic [511:0] resp_data;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  crc_if ident_crc ();
  crc_if spec_crc ();

  crc7_gen ident_crc_gen (
    .port(ident_crc.calc)
  );

  crc7_gen spec_crc_gen (
    .port(spec_crc.calc)
  );

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------
  logic [31:0] opcond_word;
  logic [127:0] ident_word;
  logic [127:0] spec_word;
  logic [63:0] config_word;
  logic [31:0] status_word;
  logic [511:0] ext_word;
  logic [119:0] spec_body;
  logic [6:0] spec_crc_used;
  logic [1:0] width_code;

  always_comb begin
    opcond_word = 32'h0000_0000;
    opcond_word[card_regs_pkg::OPC_BUSY_BIT] = st_r.ready;
    // Capacity only shown once ready so a busy card never misleads
    opcond_word[card_regs_pkg::OPC_CAP_BIT] = st_r.ready & HIGH_CAPACITY;
    opcond_word[card_regs_pkg::OPC_LV_BIT] = UHS_CAPABLE;
    opcond_word[card_regs_pkg::OPC_VDD_LSB +: 9] = card_regs_pkg::OPC_VDD_WINDOW;
  end

  assign ident_crc.data = {MAKER_CODE, APPLICATION_CODE, PRODUCT_NAME,
    PRODUCT_REVISION, SERIAL_NUMBER, 4'h0, MFG_YEAR, MFG_MONTH};
  assign ident_word = {ident_crc.data, ident_crc.crc, 1'b1};

  assign spec_body = {
    card_regs_pkg::SPEC_STRUCT, 6'h00,
    card_regs_pkg::READ_ACCESS_TIME,
    card_regs_pkg::CLOCK_ACCESS_CYCLES,
    card_regs_pkg::TRAN_SPEED_DS,
    card_regs_pkg::COMMAND_CLASSES,
    card_regs_pkg::BLOCK_LENGTH_CODE,
    1'b0, 1'b0, 1'b0,
    1'b0,
    6'h00,
    SIZE_FIELD,
    1'b0,
    1'b1,
    card_regs_pkg::ERASE_SECTOR_SIZE,
    card_regs_pkg::GROUP_SIZE,
    1'b0,
    2'b00,
    card_regs_pkg::WRITE_SPEED_FACTOR,
    card_regs_pkg::BLOCK_LENGTH_CODE,
    1'b0, 5'h00, 1'b0,
    st_r.copy, st_r.perm, st_r.tmp,
    2'b00, 2'b00};
  assign spec_crc.data = spec_body;
  // A programmed checksum stands until reset or the next accepted programming; else it tracks the content
  assign spec_crc_used = st_r.crc_prog ? st_r.spec_crc : spec_crc.crc;
  assign spec_word = {spec_body, spec_crc_used, 1'b1};

  assign config_word = {card_regs_pkg::CFG_STRUCT, card_regs_pkg::CFG_SPEC, 1'b1,
    SECURITY_VERSION, card_regs_pkg::SUPPORTED_BUS_WIDTHS, 1'b1, 4'h0, 1'b1,
    6'h00, card_regs_pkg::CFG_CMD_SUPPORT, MAKER_RESERVED};

  always_comb begin
    status_word = (st_r.err | status_evt) & card_regs_pkg::STATUS_ERR_MASK;
    status_word[card_regs_pkg::STAT_LOCK_BIT] = lock_flag;
    status_word[card_regs_pkg::STAT_ECC_DIS_BIT] = ecc_disabled;
    status_word[card_regs_pkg::STAT_ERASE_BIT] = erase_state;
    status_word[card_regs_pkg::STAT_STATE_LSB +: 4] = current_state;
    status_word[card_regs_pkg::STAT_RDY_BIT] = data_ready;
    status_word[card_regs_pkg::STAT_APP_BIT] = app_command_flag;
  end

  assign width_code = bus4_mode ? card_regs_pkg::ACTIVE_BUS_WIDTH_4
                                : card_regs_pkg::ACTIVE_BUS_WIDTH_1;
  assign ext_word = {width_code, 1'b1, 7'h00, 6'h00, 16'h0000, PROTECTED_AREA,
    card_regs_pkg::EXT_SPEED_CLASS, PERFORMANCE_MOVE, card_regs_pkg::EXT_AU_SIZE,
    4'h0, card_regs_pkg::EXT_ERASE_SIZE, card_regs_pkg::EXT_ERASE_TIMEOUT,
    card_regs_pkg::EXT_ERASE_OFFSET, card_regs_pkg::EXT_UHS_GRADE,
    card_regs_pkg::EXT_UHS_AU, 80'h0, 312'h0};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic spec_ro_differs;

  // Any difference outside the writable bits and end bit 0 is refused as an overwrite
  assign spec_ro_differs = (prog_data[127:15] != spec_word[127:15]) ||
                           (prog_data[11:8] != spec_word[11:8]);

  always_comb begin
    st_nxt = st_r;
    st_nxt.resp_valid = req_valid;
    if (init_done) begin
      st_nxt.ready = 1'b1;
    end
    if (addr_wr) begin
      st_nxt.addr = addr_data;
    end
    if (prog_valid && !spec_ro_differs) begin
      st_nxt.copy = prog_data[card_regs_pkg::SPEC_COPY_BIT];
      st_nxt.perm = prog_data[card_regs_pkg::SPEC_PERM_BIT];
      st_nxt.tmp = prog_data[card_regs_pkg::SPEC_TMP_BIT];
      st_nxt.spec_crc = prog_data[7:1];
      st_nxt.crc_prog = 1'b1;
    end
    // Errors clear once reported; a new event in the same cycle wins
    if (req_valid && req_sel == card_regs_pkg::SEL_STATUS) begin
      st_nxt.err = 32'h0000_0000;
    end
    st_nxt.err = st_nxt.err | (status_evt & card_regs_pkg::STATUS_ERR_MASK);
    if (blklen_valid && blklen != card_regs_pkg::WHOLE_BLOCK_BYTES) begin
      st_nxt.err[card_regs_pkg::STAT_BLKLEN_BIT] = 1'b1;
    end
    if (prog_valid && spec_ro_differs) begin
      st_nxt.err[card_regs_pkg::STAT_OVERWRITE_BIT] = 1'b1;
    end
    if (req_valid) begin
      case (req_sel)
        card_regs_pkg::SEL_OPCOND: st_nxt.resp_data = {480'h0, opcond_word};
        card_regs_pkg::SEL_IDENT: st_nxt.resp_data = {384'h0, ident_word};
        card_regs_pkg::SEL_SPEC: st_nxt.resp_data = {384'h0, spec_word};
        card_regs_pkg::SEL_ADDR: st_nxt.resp_data = {496'h0, st_r.addr};
        card_regs_pkg::SEL_CONFIG: st_nxt.resp_data = {448'h0, config_word};
        card_regs_pkg::SEL_STATUS: st_nxt.resp_data = {480'h0, status_word};
        card_regs_pkg::SEL_EXT: st_nxt.resp_data = ext_word;
        default: st_nxt.resp_data = 512'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign card_ready = st_r.ready;
  assign resp_valid = st_r.resp_valid;
  assign resp_data = st_r.resp_data;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  busy_report_a: assert property (
    req_valid && req_sel == card_regs_pkg::SEL_OPCOND && !st_r.ready
    |=> resp_data[31:30] == 2'b00 && resp_valid)
    else $error("conditions word not busy before ready");

  ready_sticky_a: assert property (
    init_done |=> card_ready ##1 card_ready)
    else $error("ready bit lost after init");

  low_voltage_a: assert property (
    resp_valid && $past(req_sel) == card_regs_pkg::SEL_OPCOND
    |-> resp_data[24] == UHS_CAPABLE && resp_data[23:15] == 9'h1ff)
    else $error("conditions voltage fields wrong");

  ident_frame_a: assert property (
    resp_valid && $past(req_sel) == card_regs_pkg::SEL_IDENT
    |-> resp_data[0] && resp_data[127:120] == MAKER_CODE
        && resp_data[55:24] == SERIAL_NUMBER)
    else $error("identity frame wrong");

  spec_fixed_a: assert property (
    resp_valid && $past(req_sel) == card_regs_pkg::SEL_SPEC
    |-> resp_data[119:104] == 16'h0e00 && resp_data[95:80] == 16'h5b59
        && resp_data[46:31] == 16'hff00 && resp_data[69:48] == SIZE_FIELD
        && !resp_data[76] && resp_data[0])
    else $error("fixed card data fields wrong");

  spec_write_a: assert property (
    prog_valid && !spec_ro_differs
    |=> st_r.copy == $past(prog_data[14]) && st_r.tmp == $past(prog_data[12]))
    else $error("writable flags not taken");

  spec_refuse_a: assert property (
    prog_valid && spec_ro_differs
    |=> $stable(st_r.copy) && st_r.err[16])
    else $error("read-only overwrite not refused");

  blklen_err_a: assert property (
    blklen_valid && blklen != 32'h200 |=> st_r.err[29])
    else $error("partial block length not flagged");

  event_wins_a: assert property (
    status_evt[31] && req_valid && req_sel == card_regs_pkg::SEL_STATUS
    |=> st_r.err[31] && resp_data[31])
    else $error("status event lost on read");

  addr_write_a: assert property (
    addr_wr |=> st_r.addr == $past(addr_data))
    else $error("relative address not written");

  ext_width_a: assert property (
    resp_valid && $past(req_sel) == card_regs_pkg::SEL_EXT
    |-> resp_data[511:510] == ($past(bus4_mode) ? 2'b10 : 2'b00))
    else $error("extended status width wrong");

endmodule
`default_nettype wire

// ===== dv/host_model.sv
/*
  Host-side partner of the card register set: register reads, card-data
  programming, address writes and block-length requests.
  Assumes requests are taken at the rising edge and answered one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic req_valid,
  output logic [2:0] req_sel,
  input wire logic resp_valid,
  input wire logic [511:0] resp_data,
  output logic prog_valid,
  output logic [127:0] prog_data,
  output logic addr_wr,
  output logic [15:0] addr_data,
  output logic blklen_valid,
  output logic [31:0] blklen
);
  // Write speed factor is ignored; a fixed timeout is used instead
  localparam int WRITE_TIMEOUT_MS = 250;

  initial begin
    req_valid = 1'b0;
    req_sel = 3'h0;
    prog_valid = 1'b0;
    prog_data = 128'h0;
    addr_wr = 1'b0;
    addr_data = 16'h0;
    blklen_valid = 1'b0;
    blklen = 32'h0;
  end

  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  task automatic rd(input logic [2:0] sel, output logic [511:0] d, output logic ok);
    @(negedge clk);
    req_valid = 1'b1;
    req_sel = sel;
    @(negedge clk);
    req_valid = 1'b0;
    req_sel = ~sel;
    ok = resp_valid;
    d = resp_data;
  endtask

  // Kind 0 programs card data, 1 writes the address, 2 asks a block length
  task automatic put(input logic [1:0] kind, input logic [127:0] v);
    @(negedge clk);
    prog_valid = (kind == 2'h0);
    addr_wr = (kind == 2'h1);
    blklen_valid = (kind == 2'h2);
    prog_data = v;
    addr_data = v[15:0];
    blklen = v[31:0];
    @(negedge clk);
    prog_valid = 1'b0;
    addr_wr = 1'b0;
    blklen_valid = 1'b0;
    // Released data lines must not keep the last value
    prog_data = ~prog_data;
    addr_data = ~addr_data;
    blklen = ~blklen;
  endtask

  // Capacity bit means nothing while the card is busy
  function automatic logic high_cap(input logic [31:0] opc);
    return opc[31] & opc[30];
  endfunction

  function automatic logic [31:0] capacity_kb(input logic [127:0] card_specific_data);
    return ({10'h0, card_specific_data[69:48]} + 32'h1) * 32'd512;
  endfunction

  function automatic logic block_erase_ok(input logic [127:0] card_specific_data);
    return card_specific_data[46];
  endfunction
endmodule
`default_nettype wire

// ===== dv/testbench.sv
/*
  Self-checking bench for the card register set, driven through the host
  partner. Assumes default parameters of the design.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, sys_rst, init_done, req_valid, prog_valid, addr_wr, blklen_valid;
  logic [2:0] req_sel;
  logic [127:0] prog_data;
  logic [15:0] addr_data;
  logic [31:0] blklen, status_evt;
  logic [3:0] current_state;
  logic lock_flag, data_ready, app_command_flag, ecc_disabled, erase_state, bus4_mode;
  logic card_ready, resp_valid, ok;
  logic [511:0] resp_data, d;
  logic [119:0] id_img;
  logic [127:0] csd0, prog;
  int errors, total_checks, cycles;

  card_register_set uut (.clk(clk), .sys_rst(sys_rst), .init_done(init_done),
    .req_valid(req_valid), .req_sel(req_sel), .prog_valid(prog_valid),
    .prog_data(prog_data), .addr_wr(addr_wr), .addr_data(addr_data),
    .blklen_valid(blklen_valid), .blklen(blklen), .status_evt(status_evt),
    .current_state(current_state), .lock_flag(lock_flag), .data_ready(data_ready),
    .app_command_flag(app_command_flag), .ecc_disabled(ecc_disabled),
    .erase_state(erase_state), .bus4_mode(bus4_mode), .card_ready(card_ready),
    .resp_valid(resp_valid), .resp_data(resp_data));

  host_model host (.clk(clk), .req_valid(req_valid), .req_sel(req_sel),
    .resp_valid(resp_valid), .resp_data(resp_data), .prog_valid(prog_valid),
    .prog_data(prog_data), .addr_wr(addr_wr), .addr_data(addr_data),
    .blklen_valid(blklen_valid), .blklen(blklen));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string name, input logic [511:0] exp, input logic [511:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rc(input logic [2:0] sel, input logic [511:0] exp, input string name);
    host.rd(sel, d, ok);
    chk({name, " valid"}, 512'h1, {511'h0, ok});
    chk(name, exp, d);
  endtask

  // Independent checksum, MSB first
  function automatic logic [6:0] crc7(input logic [119:0] v);
    logic [6:0] c;
    logic fb;
    c = 7'h0;
    for (int i = 119; i >= 0; i--) begin
      fb = v[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction

  function automatic logic [511:0] st_exp(input logic [31:0] err);
    logic [31:0] s;
    s = err;
    s[25] = lock_flag;
    s[14] = ecc_disabled;
    s[13] = erase_state;
    s[12:9] = current_state;
    s[8] = data_ready;
    s[5] = app_command_flag;
    return {480'h0, s};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    init_done = 1'b0;
    status_evt = 32'h0;
    current_state = 4'h0;
    {lock_flag, data_ready, app_command_flag, ecc_disabled, erase_state} = 5'h0;
    bus4_mode = 1'b0;
    id_img = {8'h5a, 16'h4142, 40'h4e4f4e414d, 8'h10, 32'h1, 4'h0, 8'h00, 4'h1};
    csd0 = 128'h400e0032_5b590000_ee877f80_0a400001;
    csd0[7:1] = crc7(csd0[127:8]);
    prog = (csd0 & ~128'hfe) | 128'h70aa;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    rc(3'h0, {480'h0, 32'h01ff_8000}, "opcond busy");
    chk("capacity ignored busy", 512'h0, {511'h0, host.high_cap(d[31:0])});
    init_done = 1'b1;
    @(negedge clk);
    init_done = 1'b0;
    rc(3'h0, {480'h0, 32'hc1ff_8000}, "opcond ready");
    chk("capacity valid ready", 512'h1, {511'h0, host.high_cap(d[31:0])});
    chk("card_ready", 512'h1, {511'h0, card_ready});
    rc(3'h1, {384'h0, id_img, crc7(id_img), 1'b1}, "identity");
    rc(3'h2, {384'h0, csd0}, "card data");
    chk("capacity", {480'h0, 32'd31264768}, {480'h0, host.capacity_kb(d[127:0])});
    chk("single block erase", 512'h1, {511'h0, host.block_erase_ok(d[127:0])});
    rc(3'h4, {448'h0, 64'h02b5_8403_0000_0000}, "config");
    rc(3'h7, 512'h0, "driver stage");
    for (int k = 0; k < 10; k++) begin
      current_state = (k == 9) ? 4'hf : k[3:0];
      {ecc_disabled, app_command_flag, data_ready, lock_flag} = current_state;
      erase_state = ~current_state[0];
      rc(3'h5, st_exp(32'h0), "status live");
    end
    host.put(2'h2, 128'd512);
    rc(3'h5, st_exp(32'h0), "whole block");
    host.put(2'h2, 128'd513);
    rc(3'h5, st_exp(32'h2000_0000), "misaligned length");
    rc(3'h5, st_exp(32'h0), "status cleared");
    // Event in the very cycle of a status read must be reported and kept
    fork
      host.rd(3'h5, d, ok);
      begin
        @(negedge clk);
        status_evt = 32'h8000_0000;
        @(negedge clk);
        status_evt = 32'h0;
      end
    join
    chk("event during read", st_exp(32'h8000_0000), d);
    rc(3'h5, st_exp(32'h8000_0000), "event kept");
    rc(3'h5, st_exp(32'h0), "event cleared");
    status_evt = 32'hffff_ffff;
    @(negedge clk);
    status_evt = 32'h0;
    rc(3'h5, st_exp(32'hfff9_8008), "error events");
    host.put(2'h0, prog);
    rc(3'h2, {384'h0, prog}, "programmed");
    host.put(2'h0, prog & ~(128'h1 << 46));
    rc(3'h2, {384'h0, prog}, "read-only kept");
    rc(3'h5, st_exp(32'h0001_0000), "overwrite error");
    host.put(2'h1, 128'hbeef);
    rc(3'h3, {496'h0, 16'hbeef}, "relative address");
    for (int w = 0; w < 2; w++) begin
      bus4_mode = w[0];
      host.rd(3'h6, d, ok);
      chk("bus width", {510'h0, w[0], 1'b0}, {510'h0, d[511:510]});
      chk("ext reserved", 512'h0, {200'h0, d[311:0]});
    end
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    chk("card_ready reset", 512'h0, {511'h0, card_ready});
    rc(3'h3, 512'h0, "address after reset");
    rc(3'h0, {480'h0, 32'h01ff_8000}, "opcond after reset");
    rc(3'h2, {384'h0, csd0}, "card data after reset");
    wrap_up();
  end
endmodule
`default_nettype wire
